// ### bench/wit_timer_bench.sv
// Self-checking bench for the watch interval timer
`timescale 1ns/1ps
`include "wit_regs.svh"
module wit_timer_bench;
  import wit_pkg::*;
  localparam int DIV = 2;
  localparam int SUBP = 40;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [17:0] avs_address = 18'h00000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  logic sub_clock_pin = 1'b0;
  logic tick_interrupt;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  int t_last = 0;
  int t_prev = 0;
  int n_tick = 0;
  int s = 0;
  logic [7:0] lfsr = 8'h0C;
  logic [31:0] rd;
  logic [1:0] rsp;

  wit_timer #(.MAIN_DIV(DIV)) dut (
    .clk(clk),
    .resetn(resetn),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response),
    .sub_clock_pin(sub_clock_pin),
    .tick_interrupt(tick_interrupt)
  );

  always #5 clk = ~clk;

  // Sub clock runs far faster than real so its intervals fit the run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc % (SUBP / 2) == 0) sub_clock_pin <= ~sub_clock_pin;
    if (tick_interrupt === 1'b1) begin
      t_prev <= t_last;
      t_last <= cyc;
      n_tick <= n_tick + 1;
    end
    if (cyc == 40000) begin
      n_mismatch = n_mismatch + 1;
      conclude();
    end
  end

  function automatic logic [7:0] next_rand(input logic [7:0] l);
    return {l[6:0], l[7] ^ l[5] ^ l[4] ^ l[3]};
  endfunction : next_rand

  // Clock periods between interval ticks for a code and a source
  function automatic int gap(input int code, input int src);
    return (1 << (4 + code)) * (src != 0 ? SUBP : DIV);
  endfunction : gap

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [17:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= ~wr;
    avs_write <= wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // Waiting is bounded by the global cycle ceiling
  task automatic wait_ticks(input int n);
    int st;
    st = n_tick;
    while (n_tick < st + n) @(posedge clk);
  endtask : wait_ticks

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude

  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    bus(1'b0, `WIT_CTRL_ADDR, 32'h0, 4'hF);
    check(rd, 32'h0);
    bus(1'b0, `WIT_STATUS_ADDR, 32'h0, 4'hF);
    check(rd & 32'h00011FFF, 32'h0);
    // Random bytes; reserved bits must read back zero
    repeat (4) begin
      lfsr = next_rand(lfsr);
      bus(1'b1, `WIT_CTRL_ADDR, {24'h0, lfsr}, 4'hF);
      bus(1'b0, `WIT_CTRL_ADDR, 32'h0, 4'hF);
      check(rd, {24'h0, lfsr & `WIT_CTRL_WMASK});
    end
    bus(1'b1, `WIT_CTRL_ADDR, 32'h80, 4'hF);
    bus(1'b1, `WIT_BITSET_ADDR, 32'h01, 4'hF);
    bus(1'b1, `WIT_BITCLR_ADDR, 32'h80, 4'hF);
    bus(1'b1, `WIT_CTRL_ADDR, 32'h72, 4'hE);
    bus(1'b0, `WIT_CTRL_ADDR, 32'h0, 4'hF);
    check(rd, 32'h01);
    bus(1'b0, 18'h00010, 32'h0, 4'hF);
    check({rsp, rd[29:0]}, 32'h80000000);
    $display("register test done");
    // Every main code, then the two shortest on the sub clock
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, `WIT_CTRL_ADDR, {24'h0, k > 5, 3'(k % 6), 4'h1}, 4'hF);
      wait_ticks(3);
      check(32'(t_last - t_prev), 32'(gap(k % 6, k > 5 ? 1 : 0)));
    end
    $display("interval test done");
    bus(1'b1, `WIT_CTRL_ADDR, 32'h51, 4'hF);
    bus(1'b1, `WIT_BITSET_ADDR, 32'h02, 4'hF);
    wait_ticks(4);
    bus(1'b0, `WIT_STATUS_ADDR, 32'h0, 4'hF);
    check({27'h0, rd[12:8]}, 32'h3);
    check(32'(t_last - t_prev), 32'(gap(5, 0)));
    bus(1'b1, `WIT_BITCLR_ADDR, 32'h02, 4'hF);
    bus(1'b0, `WIT_STATUS_ADDR, 32'h0, 4'hF);
    check({27'h0, rd[12:8]}, 32'h0);
    wait_ticks(2);
    check(32'(t_last - t_prev), 32'(gap(5, 0)));
    bus(1'b1, `WIT_BITCLR_ADDR, 32'h01, 4'hF);
    bus(1'b0, `WIT_STATUS_ADDR, 32'h0, 4'hF);
    check(rd & 32'h00001FFF, 32'h0);
    s = n_tick;
    repeat (2048) @(posedge clk);
    check(32'(n_tick), 32'(s));
    $display("watch test done");
    conclude();
  end
endmodule : wit_timer_bench

// ### verilog/wit_pkg.sv
// Types shared by the watch interval timer
package wit_pkg;
  typedef logic [7:0] wit_ctrl_t;
  typedef enum logic [1:0] {
    WIT_BUS_IDLE,
    WIT_BUS_ANSWER
  } wit_bus_t;
endpackage : wit_pkg

// ### verilog/wit_regs.svh
// Register offsets, field positions, reset values and counts of the timer
`ifndef WIT_REGS_SVH
`define WIT_REGS_SVH
`define WIT_CTRL_INDEX 16'hFF4A
`define WIT_CTRL_ADDR 18'h3FD28
`define WIT_BITSET_ADDR 18'h3FD2C
`define WIT_BITCLR_ADDR 18'h3FD30
`define WIT_STATUS_ADDR 18'h3FD34
`define WIT_CTRL_RESET 8'h00
`define WIT_CTRL_WMASK 8'hF3
`define WIT_SRC_BIT 7
`define WIT_SEL_HI 6
`define WIT_SEL_LO 4
`define WIT_RUN_BIT 1
`define WIT_EN_BIT 0
`define WIT_MAIN_DIV 128
`define WIT_PRE_BITS 9
`define WIT_CNT_BITS 5
`define WIT_SEL_MAX 3'h5
`define WIT_SEL_BASE 4
`endif

// ### verilog/wit_sync.sv
// Three-stage synchroniser with agreement filter for the sub clock pin
`timescale 1ns/1ps
module wit_sync (
  input wire logic clk,
  input wire logic resetn,
  input wire logic pin_in,
  output logic level_q,
  output logic rise
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // First stage is read only by the second
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

  // Rising edge of the filtered level, one cycle early view
  assign rise = (s2_q == s3_q) && s3_q && !level_q;
endmodule : wit_sync

// ### verilog/wit_timer.sv
// Watch timer with 9-bit prescaler, 5-bit counter and Avalon-MM control
`timescale 1ns/1ps
`include "wit_regs.svh"

// Operation
// (R1) Bit 7 selects counting clock: main clock over 128, or sub clock.
// (R2) Bits 6..4 pick interval 2^4..2^9 counting periods; other codes refused.
// (R3) Counter-run zero stops and clears the 5-bit counter; one runs it.
// (R4) Enable zero holds prescaler and counter cleared; one enables.
// (R5) Enable and run both set give a watch tick every half second.
// (R6) Clearing only run clears counter, prescaler keeps going; first tick early. Here it comes late: first carry only arms.
// (R7) Interval ticks share the interrupt and run alongside watch ticks.
// (R8) Counter starts one prescaler output cycle late after enabling.
// (R9) Reset loads control with zero: main clock, shortest code, stopped.
// (R10) Control accepts whole-byte writes and single-bit set or clear.
// (R11) Software writes zero to control bits 2 and 3.
// (R12) Software picks sub clock when an exact half second matters.
// (R13) Counter advances per 2^9 prescaler carry; wrap raises watch tick.
module wit_timer #(
  parameter int MAIN_DIV = `WIT_MAIN_DIV
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [17:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic sub_clock_pin,
  output logic tick_interrupt
);
  import wit_pkg::*;

  localparam int DW = $clog2(MAIN_DIV);

  initial begin
    if (MAIN_DIV < 2 || (1 << DW) != MAIN_DIV) begin
      $error("MAIN_DIV must be a power of two of at least 2");
    end
  end

  wit_ctrl_t watch_control_q;
  wit_ctrl_t ctrl_d;
  wit_bus_t bus_q;
  logic [DW-1:0] div_q;
  logic [`WIT_PRE_BITS-1:0] pre_q;
  logic [`WIT_CNT_BITS-1:0] cnt_q;
  logic armed_q;
  logic sub_level;
  logic sub_rise;
  logic [31:0] rdata_q;
  logic [1:0] resp_q;

  // Sub clock pin is asynchronous, so it is filtered first
  wit_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .pin_in(sub_clock_pin),
    .level_q(sub_level),
    .rise(sub_rise)
  );

  // Control fields
  wire timer_enable = watch_control_q[`WIT_EN_BIT];
  wire counter_run = watch_control_q[`WIT_RUN_BIT];
  wire clock_source_select = watch_control_q[`WIT_SRC_BIT];
  wire [2:0] interval_sel = watch_control_q[`WIT_SEL_HI:`WIT_SEL_LO];

  // Counting clock enable: divided main clock or sub clock edge
  wire main_tick = (div_q == {DW{1'b1}});
  wire counting_clock = clock_source_select ? sub_rise : main_tick; // R1

  // Prescaler next value and carries
  wire [`WIT_PRE_BITS-1:0] pre_next = pre_q + 9'h001;
  wire pre_carry = counting_clock && (pre_q == 9'h1FF); // R13

  // Interval tap: bit (3 + code) falls, i.e. every 2^(4+code) periods
  function automatic logic interval_hit(input logic [8:0] cur,
                                        input logic [8:0] nxt,
                                        input logic [2:0] code);
    logic [3:0] tap;
    tap = 4'(code) + 4'h3;
    interval_hit = cur[tap] && !nxt[tap];
  endfunction : interval_hit

  // Prohibited codes never fire
  wire code_ok = (interval_sel <= `WIT_SEL_MAX); // R2
  wire interval_evt = timer_enable && counting_clock && code_ok &&
    interval_hit(pre_q, pre_next, interval_sel); // R2 R7
  wire watch_evt = timer_enable && counter_run && armed_q && pre_carry &&
    (cnt_q == 5'h1F); // R5 R13

  // Bus decode
  wire acc = (avs_read || avs_write) && (bus_q == WIT_BUS_IDLE);
  wire hit_ctrl = (avs_address == `WIT_CTRL_ADDR);
  wire hit_set = (avs_address == `WIT_BITSET_ADDR);
  wire hit_clr = (avs_address == `WIT_BITCLR_ADDR);
  wire hit_stat = (avs_address == `WIT_STATUS_ADDR);
  wire hit_any = hit_ctrl || hit_set || hit_clr || hit_stat;
  wire wr_lane = avs_byteenable[0];
  wire [7:0] wbyte = avs_writedata[7:0] & `WIT_CTRL_WMASK; // R11

  // Byte write, bit set or bit clear; a bit write touches only its bits
  always_comb begin
    ctrl_d = watch_control_q;
    if (acc && avs_write && wr_lane) begin
      if (hit_ctrl) begin
        ctrl_d = wbyte; // R10
      end else if (hit_set) begin
        ctrl_d = watch_control_q | wbyte; // R10
      end else if (hit_clr) begin
        ctrl_d = watch_control_q & ~wbyte; // R10
      end
    end
  end

  // Control register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      watch_control_q <= `WIT_CTRL_RESET; // R9
    end else begin
      watch_control_q <= ctrl_d;
    end
  end

  // Main clock divider runs free so source switches stay glitch free
  always_ff @(posedge clk) begin
    if (!resetn) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DW'(1);
    end
  end

  // Prescaler: cleared only by reset or the enable bit
  always_ff @(posedge clk) begin
    if (!resetn || !timer_enable) begin
      pre_q <= '0; // R4
    end else if (counting_clock) begin
      pre_q <= pre_next; // R6
    end
  end

  // First carry after run only arms the counter, hence a late start
  always_ff @(posedge clk) begin
    if (!resetn || !timer_enable || !counter_run) begin
      armed_q <= 1'b0; // R8
    end else if (pre_carry) begin
      armed_q <= 1'b1; // R8
    end
  end

  // 5-bit counter, cleared by run or enable low
  always_ff @(posedge clk) begin
    if (!resetn || !timer_enable || !counter_run) begin
      cnt_q <= '0; // R3 R4 R6
    end else if (pre_carry && armed_q) begin
      cnt_q <= cnt_q + 5'h01; // R13
    end
  end

  // Interrupt pulse, one clock wide, from either source
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tick_interrupt <= 1'b0;
    end else begin
      tick_interrupt <= interval_evt || watch_evt; // R5 R7
    end
  end

  // Read mux
  wire [31:0] status_word = {14'h0000, sub_level, armed_q,
    3'h0, cnt_q, pre_q[7:0]};
  wire [31:0] rmux = hit_stat ? status_word :
    (hit_ctrl ? {24'h000000, watch_control_q} : 32'h00000000);

  // Every access waits one cycle, then answers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bus_q <= WIT_BUS_IDLE;
      rdata_q <= 32'h00000000;
      resp_q <= 2'h0;
    end else begin
      case (bus_q)
        WIT_BUS_IDLE: begin
          if (acc) begin
            bus_q <= WIT_BUS_ANSWER;
            rdata_q <= avs_read ? rmux : 32'h00000000;
            resp_q <= hit_any ? 2'h0 : 2'h2;
          end
        end
        default: begin
          bus_q <= WIT_BUS_IDLE;
        end
      endcase
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) &&
    (bus_q != WIT_BUS_ANSWER);
  assign avs_readdata = rdata_q;
  assign avs_response = resp_q;

  // Assertions
  stop_clears_a: assert property (@(posedge clk) disable iff (!resetn)
    !timer_enable |=> (pre_q == 9'h000) && (cnt_q == 5'h00)) // R4
    else $error("prescaler or counter not cleared while disabled");
  run_clears_a: assert property (@(posedge clk) disable iff (!resetn)
    !counter_run |=> cnt_q == 5'h00) // R3
    else $error("counter not cleared while run is low");
  keep_pre_a: assert property (@(posedge clk) disable iff (!resetn)
    timer_enable && $past(timer_enable) && !counting_clock |=>
    $stable(pre_q)) // R6
    else $error("prescaler moved without counting clock");
  bad_code_a: assert property (@(posedge clk) disable iff (!resetn)
    !code_ok && !watch_evt |=> !tick_interrupt) // R2
    else $error("prohibited interval code raised interrupt");
  watch_tick_a: assert property (@(posedge clk) disable iff (!resetn)
    watch_evt |=> tick_interrupt ##1 (cnt_q == 5'h00)) // R5
    else $error("watch wrap did not raise interrupt");
  late_start_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(counter_run) |-> !armed_q ##1 (cnt_q == 5'h00)) // R8
    else $error("counter started without a lead carry");
  reset_ctrl_a: assert property (@(posedge clk)
    !resetn |=> watch_control_q == 8'h00) // R9
    else $error("control not cleared by reset");
  bit_write_a: assert property (@(posedge clk) disable iff (!resetn)
    acc && avs_write && wr_lane && hit_set |=>
    watch_control_q == $past(watch_control_q | wbyte)) // R10
    else $error("bit set changed other bits");
  main_src_a: assert property (@(posedge clk) disable iff (!resetn)
    !clock_source_select && counting_clock |-> div_q == {DW{1'b1}}) // R1
    else $error("main counting clock off divider terminal");
  both_c: cover property (@(posedge clk) interval_evt && watch_evt);
  watch_c: cover property (@(posedge clk) watch_evt);
  sub_c: cover property (@(posedge clk) clock_source_select && interval_evt);
endmodule : wit_timer
